// File: rtl/lcd_frame_regs.svh
`ifndef LCD_FRAME_REGS_SVH
`define LCD_FRAME_REGS_SVH
// Register offsets
`define OFS_CTRL_A      8'he4
`define OFS_CTRL_B      8'he5
`define OFS_FRAME_RATE  8'he6
`define OFS_CONTRAST    8'he7
`define OFS_MEM_BASE    8'hec
`define MEM_BYTES       5'h14
// control_reg_a fields
`define CA_ENABLE       7
`define CA_LOWPWR       6
`define CA_FLAG         4
`define CA_INT_EN       3
`define CA_BUF_DIS      2
`define CA_CCD          1
`define CA_BLANK        0
// control_reg_b fields
`define CB_CLK_SRC      7
`define CB_HALF_BIAS    6
`define CB_DUTY_HI      5
`define CB_DUTY_LO      4
`define CB_MASK_HI      3
// Reset values
`define RST_CTRL_A      8'h00
`define RST_CTRL_B      8'h00
`define RST_FRAME_RATE  8'h00
`define RST_CONTRAST    8'h00
// Sleep mode codes seen on sleepMode
`define SLP_ACTIVE      3'h0
`define SLP_IDLE        3'h1
`define SLP_ADCNR       3'h2
`define SLP_PDOWN       3'h3
`define SLP_PSAVE       3'h4
`define SLP_STANDBY     3'h5
`endif

// File: rtl/lcd_frame_pkg.sv
package lcd_frame_pkg;
    // Frame sequencer state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } frame_state_t;
    // Duty codes
    typedef enum logic [1:0] {
        DUTY_STATIC = 2'b00,
        DUTY_HALF   = 2'b01,
        DUTY_THIRD  = 2'b10,
        DUTY_QUART  = 2'b11
    } duty_t;
endpackage : lcd_frame_pkg

// File: rtl/lcd_pin_mask.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_frame_regs.svh"
module lcd_pin_mask
    import lcd_frame_pkg::*;
#(
    parameter int SEG_COUNT = 40
) (
    // Configuration
    input  wire logic [3:0]           portMask,
    input  wire logic [1:0]           dutySel,
    // Pin ownership
    output logic      [SEG_COUNT-1:0] segOwn,
    output logic      [3:0]           comOwn
);
    // Segments kept per mask code; top codes take every pin
    function automatic logic [5:0] segsUsed(input logic [3:0] code);
        case (code)
            4'h0: segsUsed = 6'd13;
            4'h1: segsUsed = 6'd15;
            4'h2: segsUsed = 6'd17;
            4'h3: segsUsed = 6'd19;
            4'h4: segsUsed = 6'd21;
            4'h5: segsUsed = 6'd23;
            4'h6: segsUsed = 6'd24;
            4'h7: segsUsed = 6'd25;
            4'h8: segsUsed = 6'd27;
            4'h9: segsUsed = 6'd29;
            4'ha: segsUsed = 6'd31;
            4'hb: segsUsed = 6'd33;
            4'hc: segsUsed = 6'd35;
            4'hd: segsUsed = 6'd37;
            default: segsUsed = 6'd40;
        endcase
    endfunction : segsUsed

    // Masked segment pins go back to port use
    genvar s;
    generate
        for (s = 0; s < SEG_COUNT; s = s + 1) begin : g_seg
            assign segOwn[s] = (6'(s) < segsUsed(portMask));
        end
    endgenerate

    // Commons 0..duty belong to the display
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_com
            assign comOwn[c] = (2'(c) <= dutySel);
        end
    endgenerate
endmodule : lcd_pin_mask
`default_nettype wire

// File: rtl/lcd_frame_ctrl.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_frame_regs.svh"
module lcd_frame_ctrl
    import lcd_frame_pkg::*;
#(
    parameter int SEG_COUNT = 40
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic      [7:0]           regRdata,
    // Clock source and sleep
    input  wire logic                 timer_osc_in_pin,
    input  wire logic                 ext_clock_input_en,
    input  wire logic                 sysClkIsRc,
    input  wire logic [2:0]           sleepMode,
    output logic                      extClkBufEn,
    output logic                      lcdClockActive,
    // Segment and common drive
    output logic      [SEG_COUNT-1:0] segLevel,
    output logic      [SEG_COUNT-1:0] segOwn,
    output logic      [3:0]           comSelect,
    output logic                      comLevel,
    output logic      [3:0]           comOwn,
    // Frame status and latched settings
    output logic                      frameIrq,
    output logic                      halfBiasOut,
    output logic                      lowPowerOut,
    output logic                      blankedOut,
    output logic      [7:0]           contrastOut
);
    // Refuse segment counts the mask table cannot serve
    if (SEG_COUNT < 13 || SEG_COUNT > 40) begin : g_bad_seg
        $error("SEG_COUNT must lie in 13..40");
    end

    // ----------------------------------------
    // Reset release and register decode
    // ----------------------------------------
    logic        rstS1, rstN;       // Reset synchroniser
    logic [7:0]  ctrlA_reg;         // control_reg_a
    logic [7:0]  ctrlB_reg;         // control_reg_b
    logic [7:0]  frame_rate_reg;    // Slot length
    logic [7:0]  contrast_ctrl_reg; // Contrast value
    logic [7:0]  memReg [20];       // Display memory
    logic        flag_reg;          // frame_start_flag

    // Async assert, synchronous release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstS1 <= 1'b0;
            rstN  <= 1'b0;
        end else begin
            rstS1 <= 1'b1;
            rstN  <= rstS1;
        end
    end

    // Display memory window decode
    function automatic logic isMem(input logic [7:0] a);
        // Nine bits: the window runs to the top of the address space
        isMem = (a >= `OFS_MEM_BASE) && ({1'b0, a} < 9'(`OFS_MEM_BASE) + 9'(`MEM_BYTES));
    endfunction : isMem

    function automatic logic [4:0] memIdx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `OFS_MEM_BASE;
        memIdx = d[4:0];
    endfunction : memIdx

    logic wrA;  // Write to control_reg_a
    assign wrA = regWr && (regAddr == `OFS_CTRL_A);

    logic enable;        // controller_enable
    logic lowPowerWrite; // low_power_wave_sel as written
    logic clkSrcAsync;   // lcd_clk_source_sel
    logic [1:0] dutySel; // duty_select
    assign enable        = ctrlA_reg[`CA_ENABLE];
    assign lowPowerWrite = ctrlA_reg[`CA_LOWPWR];
    assign clkSrcAsync   = ctrlB_reg[`CB_CLK_SRC];
    assign dutySel       = ctrlB_reg[`CB_DUTY_HI:`CB_DUTY_LO];

    // Control registers; flag handled apart
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlA_reg         <= `RST_CTRL_A;
            ctrlB_reg         <= `RST_CTRL_B;
            frame_rate_reg    <= `RST_FRAME_RATE;
            contrast_ctrl_reg <= `RST_CONTRAST;
        end else if (regWr) begin
            case (regAddr)
                // Reserved and flag positions kept zero here
                `OFS_CTRL_A:     ctrlA_reg <= regWdata & 8'hcf;
                `OFS_CTRL_B:     ctrlB_reg <= regWdata;
                `OFS_FRAME_RATE: frame_rate_reg <= regWdata;
                `OFS_CONTRAST:   contrast_ctrl_reg <= regWdata;
                default: ;
            endcase
        end
    end

    // Display memory; blanking never touches it
    // memory preserved
    always_ff @(posedge ref_clk) begin
        if (regWr && isMem(regAddr)) begin
            memReg[memIdx(regAddr)] <= regWdata;
        end
    end

    // ----------------------------------------
    // Clock source and sleep behaviour
    // ----------------------------------------
    logic oscS1, oscS2, oscS3; // Oscillator pin sync and edge
    logic runOk;               // Frame clock present
    logic srcTick;             // One source clock event

    // Two flops before any logic sees the pin
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            oscS1 <= 1'b0;
            oscS2 <= 1'b0;
            oscS3 <= 1'b0;
        end else begin
            oscS1 <= timer_osc_in_pin;
            oscS2 <= oscS1;
            oscS3 <= oscS2;
        end
    end

    // Which sleep modes keep the frame clock alive
    always_comb begin
        if (!clkSrcAsync) begin
            runOk = (sleepMode == `SLP_ACTIVE) || (sleepMode == `SLP_IDLE)
                 || (sleepMode == `SLP_PSAVE);
        end else if (sysClkIsRc) begin
            runOk = (sleepMode == `SLP_ACTIVE) || (sleepMode == `SLP_IDLE)
                 || (sleepMode == `SLP_ADCNR) || (sleepMode == `SLP_PSAVE);
        end else begin
            // Async source without RC system clock: active only
            runOk = (sleepMode == `SLP_ACTIVE);
        end
    end

    assign srcTick = runOk && (clkSrcAsync ? (oscS2 && !oscS3) : 1'b1);

    // Pin buffer and clock status outputs
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            extClkBufEn    <= 1'b0;
            lcdClockActive <= 1'b0;
        end else begin
            extClkBufEn    <= ext_clock_input_en && clkSrcAsync;
            lcdClockActive <= enable && runOk;
        end
    end

    // ----------------------------------------
    // Slot prescaler and frame sequencer
    // ----------------------------------------
    frame_state_t state_reg;   // Sequencer state
    logic [11:0] slotCnt_reg;  // Source ticks in slot
    logic [1:0]  comIdx_reg;   // Addressed common
    logic        skipNext_reg; // Next frame reuses data
    logic        slotTick;     // Slot ends
    logic        frameStart;   // New frame begins
    logic        latchNow;     // Latch point

    assign slotTick = srcTick && (slotCnt_reg >= {frame_rate_reg, 4'hf});
    assign frameStart = slotTick
        && ((state_reg == ST_IDLE) || (comIdx_reg == dutySel));
    assign latchNow = frameStart && !skipNext_reg;

    // Prescaler restarts with the controller
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            slotCnt_reg <= 12'h000;
        end else if (!enable || slotTick) begin
            slotCnt_reg <= 12'h000;
        end else if (srcTick) begin
            slotCnt_reg <= slotCnt_reg + 12'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_reg  <= ST_IDLE;
            comIdx_reg <= 2'b00;
        end else if (!enable) begin
            state_reg  <= ST_IDLE;
            comIdx_reg <= 2'b00;
        end else if (slotTick) begin
            state_reg <= ST_RUN;
            comIdx_reg <= frameStart ? 2'b00 : comIdx_reg + 2'b01;
        end
    end

    // ----------------------------------------
    // Frame-synchronous latching
    // ----------------------------------------
    logic [39:0] rowLat [4];   // Latched memory per common
    logic        blankLat;     // Latched blank_request
    logic        lowPowerLat;  // Latched waveform select
    logic        halfBiasLat;  // Bias at latch time

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            blankLat          <= 1'b0;
            lowPowerLat       <= 1'b0;
            halfBiasLat       <= 1'b0;
            contrastOut       <= `RST_CONTRAST;
            skipNext_reg      <= 1'b0;
        end else if (!enable) begin
            skipNext_reg <= 1'b0;
        end else if (latchNow) begin
            blankLat     <= ctrlA_reg[`CA_BLANK];
            lowPowerLat  <= lowPowerWrite;
            halfBiasLat  <= ctrlB_reg[`CB_HALF_BIAS];
            contrastOut  <= contrast_ctrl_reg;
            // repeat data in the pair frame
            skipNext_reg <= lowPowerWrite;
        end else if (frameStart) begin
            skipNext_reg <= 1'b0;
        end
    end

    // Rows gathered from five bytes each
    genvar r;
    generate
        for (r = 0; r < 4; r = r + 1) begin : g_row
            always_ff @(posedge ref_clk) begin
                if (latchNow) begin
                    rowLat[r] <= {memReg[5*r+4], memReg[5*r+3], memReg[5*r+2],
                                  memReg[5*r+1], memReg[5*r]};
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Frame flag
    // ----------------------------------------
    // Set wins over a one written in the same cycle
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            flag_reg <= 1'b0;
        end else if (latchNow) begin
            flag_reg <= 1'b1;
        end else if (wrA && regWdata[`CA_FLAG]) begin
            flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Waveform polarity and pin drive
    // ----------------------------------------
    logic pol_reg;  // Drive phase
    logic [SEG_COUNT-1:0] maskSeg;
    logic [3:0]           maskCom;

    // Default flips each slot and frame; low power only per frame
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pol_reg <= 1'b0;
        end else if (!enable) begin
            pol_reg <= 1'b0;
        end else if (frameStart) begin
            pol_reg <= !pol_reg;
        end else if (slotTick && !lowPowerLat) begin
            pol_reg <= !pol_reg;
        end
    end

    lcd_pin_mask #(
        .SEG_COUNT (SEG_COUNT)
    ) u_mask (
        .portMask (ctrlB_reg[`CB_MASK_HI:0]),
        .dutySel  (dutySel),
        .segOwn   (maskSeg),
        .comOwn   (maskCom)
    );

    // Registered drive of every pin
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            segLevel  <= '0;
            comSelect <= 4'h0;
            comLevel  <= 1'b0;
        end else if (!enable || blankLat || state_reg == ST_IDLE) begin
            segLevel  <= '0;
            comSelect <= 4'h0;
            comLevel  <= 1'b0;
        end else begin
            segLevel  <= rowLat[comIdx_reg][SEG_COUNT-1:0] ^ {SEG_COUNT{pol_reg}};
            comSelect <= 4'h1 << comIdx_reg;
            comLevel  <= !pol_reg;
        end
    end

    // Pin ownership follows enable, mask and duty
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            segOwn <= '0;
            comOwn <= 4'h0;
        end else begin
            segOwn <= enable ? maskSeg : '0;
            comOwn <= enable ? maskCom : 4'h0;
        end
    end

    // Status outputs
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            frameIrq    <= 1'b0;
            halfBiasOut <= 1'b0;
            lowPowerOut <= 1'b0;
            blankedOut  <= 1'b0;
        end else begin
            frameIrq    <= flag_reg && ctrlA_reg[`CA_INT_EN];
            halfBiasOut <= halfBiasLat;
            lowPowerOut <= lowPowerLat;
            blankedOut  <= enable && blankLat;
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            regRdata <= 8'h00;
        end else if (!regRd) begin
            regRdata <= 8'h00;
        end else if (isMem(regAddr)) begin
            regRdata <= memReg[memIdx(regAddr)];
        end else begin
            case (regAddr)
                `OFS_CTRL_A:     regRdata <= ctrlA_reg | {3'h0, flag_reg, 4'h0};
                `OFS_CTRL_B:     regRdata <= ctrlB_reg;
                `OFS_FRAME_RATE: regRdata <= frame_rate_reg;
                `OFS_CONTRAST:   regRdata <= contrast_ctrl_reg;
                default:         regRdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_flag_clear;
        (wrA && regWdata[`CA_FLAG] && !latchNow) |=> !flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_set;
        latchNow |=> flag_reg ##1 (frameIrq == $past(ctrlA_reg[`CA_INT_EN]));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set at frame");

    property p_lp_skip;
        (frameStart && skipNext_reg) |=> $stable(rowLat[0]) && !skipNext_reg;
    endproperty
    a_lp_skip: assert property (p_lp_skip) else $error("low power latched twice");

    property p_off_now;
        (wrA && !regWdata[`CA_ENABLE]) |=> ##1 (segOwn == '0 && comOwn == 4'h0);
    endproperty
    a_off_now: assert property (p_off_now) else $error("pins kept after disable");

    property p_blank_gnd;
        blankLat |=> (segLevel == '0 && comSelect == 4'h0 && !comLevel);
    endproperty
    a_blank_gnd: assert property (p_blank_gnd) else $error("blank not grounded");

    property p_blank_wait;
        (wrA && regWdata[`CA_BLANK] && !blankLat && !latchNow) |=> !blankLat;
    endproperty
    a_blank_wait: assert property (p_blank_wait) else $error("blank mid frame");

    property p_latch_row;
        latchNow |=> rowLat[0][7:0] == $past(memReg[0]);
    endproperty
    a_latch_row: assert property (p_latch_row) else $error("row not latched");

    property p_static_com;
        (enable && dutySel == DUTY_STATIC) |=> (comOwn[3:1] == 3'h0 || !$past(enable, 1));
    endproperty
    a_static_com: assert property (p_static_com) else $error("spare common kept");

    property p_ext_buf;
        ##1 extClkBufEn == $past(ext_clock_input_en && clkSrcAsync);
    endproperty
    a_ext_buf: assert property (p_ext_buf) else $error("clock buffer wrong");

    c_lp_frame: cover property (latchNow && lowPowerWrite);
    c_blank:    cover property (blankedOut);
    c_quarter:  cover property (frameStart && dutySel == DUTY_QUART);
endmodule : lcd_frame_ctrl
`default_nettype wire

// File: dv/lcd_glass_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model #(
    parameter int SEG_COUNT = 40
) (
    // Drive from the controller
    input  wire logic                 ref_clk,
    input  wire logic [SEG_COUNT-1:0] segLevel,
    input  wire logic [3:0]           comSelect,
    input  wire logic                 comLevel,
    // Pattern seen on each common row
    output logic      [SEG_COUNT-1:0] litRow [4]
);
    // ----------------------------------------
    // Row capture
    // ----------------------------------------
    // Decode against common phase, so a polarity flip must not change the row
    // rows by common
    always_ff @(posedge ref_clk) begin
        for (int c = 0; c < 4; c++) begin
            if (comSelect[c]) begin
                litRow[c] <= segLevel ^ {SEG_COUNT{~comLevel}};
            end
        end
    end
endmodule : lcd_glass_model
`default_nettype wire

// File: dv/segment_lcd_frame_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_frame_control_bench;
    import lcd_frame_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, contrastOut;
    logic oscPin = 1'b0, extEn = 1'b0, isRc = 1'b0, extClkBufEn, lcdClockActive, comLevel;
    logic [2:0] sleepMode = 3'h0;
    logic [39:0] segLevel, segOwn;
    logic [39:0] litRow [4];
    logic [3:0] comSelect, comOwn;
    logic frameIrq, halfBiasOut, lowPowerOut, blankedOut, irqPrev = 1'b0;
    logic [7:0] mem [20];
    logic [7:0] expQ [$];   // Expected read data, oldest first
    int error_cnt = 0, n_compared = 0, cyc = 0, gapCnt = 0, irqGap = 0, defGap, oscCnt = 0;
    int nSeg [16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 40, 40};
    logic act;
    always #2 ref_clk = ~ref_clk;
    // Slow oscillator pin, changed on the sampling edge by nonblocking assignment
    always @(posedge ref_clk) begin
        oscCnt <= oscCnt + 1;
        oscPin <= oscCnt[2];
    end
    lcd_frame_ctrl #(.SEG_COUNT(40)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .timer_osc_in_pin(oscPin),
        .ext_clock_input_en(extEn), .sysClkIsRc(isRc), .sleepMode(sleepMode), .extClkBufEn(extClkBufEn),
        .lcdClockActive(lcdClockActive), .segLevel(segLevel), .segOwn(segOwn), .comSelect(comSelect),
        .comLevel(comLevel), .comOwn(comOwn), .frameIrq(frameIrq), .halfBiasOut(halfBiasOut),
        .lowPowerOut(lowPowerOut), .blankedOut(blankedOut), .contrastOut(contrastOut));
    lcd_glass_model #(.SEG_COUNT(40)) i_glass (.ref_clk(ref_clk), .segLevel(segLevel),
        .comSelect(comSelect), .comLevel(comLevel), .litRow(litRow));
    // ----------------------------------------
    // Compare, bus and frame tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkRd(input logic [7:0] got, input logic [7:0] exp);
        chk(64'(got), 64'(exp));
    endtask : chkRd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask : rd
    // Wait for the frame flag, then clear it with a one
    task automatic waitIrq(input logic [7:0] ca);
        int n;
        n = 0;
        while (frameIrq !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        chk(frameIrq, 1'b1);
        wr(8'he4, ca | 8'h10);
        repeat (3) @(posedge ref_clk);
    endtask : waitIrq
    task automatic results();
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // ----------------------------------------
    // Watchers: read data, flag spacing, timeout
    // ----------------------------------------
    always @(posedge ref_clk) begin
        rdSeen <= regRd;
        irqPrev <= frameIrq;
        gapCnt <= (frameIrq === 1'b1 && irqPrev !== 1'b1) ? 1 : gapCnt + 1;
        if (frameIrq === 1'b1 && irqPrev !== 1'b1) irqGap <= gapCnt;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end
    // Read data stands only in the cycle after the strobe
    always @(negedge ref_clk) if (rdSeen && expQ.size() > 0) chkRd(regRdata, expQ.pop_front());
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(58));
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (mem[k]) begin
            mem[k] = 8'($urandom);
            rd(8'he4 + 8'(k % 6), 8'h00);  // Reset values and unmapped e8, e9
            wr(8'hec + 8'(k), mem[k]);
            rd(8'hec + 8'(k), mem[k]);
        end
        wr(8'he6, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(8'he4, 8'h00);
            wr(8'he5, {2'b00, 2'(i), 4'(i)});
            wr(8'he4, 8'h88);
            repeat (3) @(posedge ref_clk);
            chk(comOwn, (4'h2 << i[1:0]) - 4'h1);
            chk(segOwn, (64'h1 << nSeg[i]) - 64'h1);
        end
        wr(8'he4, 8'h00);
        wr(8'he5, 8'h3f);
        wr(8'he4, 8'h88);
        wr(8'he7, 8'h5a);
        repeat (3) waitIrq(8'h88);
        defGap = irqGap;
        chk(32'(defGap), 32'd64);
        chk({halfBiasOut, contrastOut}, 9'h05a);
        for (int c = 0; c < 4; c++)
            chk(litRow[c], {mem[5*c+4], mem[5*c+3], mem[5*c+2], mem[5*c+1], mem[5*c]});
        wr(8'he4, 8'hc8);
        repeat (3) waitIrq(8'hc8);
        chk({lowPowerOut, 32'(irqGap)}, {1'b1, 32'd128});
        wr(8'he4, 8'h99);
        chk(blankedOut, 1'b0);
        waitIrq(8'h89);
        chk({blankedOut, comSelect, segLevel}, {1'b1, 44'h0});
        rd(8'hec, mem[0]);
        wr(8'he4, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk({comOwn, segOwn, lcdClockActive}, 45'h0);
        for (int i = 0; i < 24; i++) begin
            wr(8'he4, 8'h00);
            sleepMode <= 3'(i % 6);
            isRc <= i[3];
            extEn <= 1'($urandom);
            wr(8'he5, {i[4], 7'h3f});
            // Sync clock: display stays off in deep sleep
            wr(8'he4, (!i[4] && (i % 6 == 2 || i % 6 == 3 || i % 6 == 5)) ? 8'h00 : 8'h88);
            repeat (3) @(posedge ref_clk);
            act = (i % 6 == 0) || (!i[4] && (i % 6 == 1 || i % 6 == 4))
                || (i[4] && i[3] && (i % 6 == 1 || i % 6 == 2 || i % 6 == 4));
            chk({lcdClockActive, extClkBufEn}, {act, extEn & i[4]});
        end
        // Async source on RC, half bias, two commons: 2 slots of 16 ticks, 8 cycles each
        wr(8'he4, 8'h00);
        sleepMode <= 3'h0;
        isRc <= 1'b1;
        wr(8'he5, 8'hdf);
        wr(8'he4, 8'h88);
        repeat (2) waitIrq(8'h88);
        chk({halfBiasOut, 32'(irqGap)}, {1'b1, 32'd256});
        results();
    end
endmodule : segment_lcd_frame_control_bench
`default_nettype wire
